// File: rtl/flash_ctl_pkg.sv
// Constants, types and helpers of the flash read and program controller
package flash_ctl_pkg;
   localparam logic [1:0] RGN_CSR = 2'h2;
   localparam logic [5:0] OFS_CFG = 6'h00;
   localparam logic [5:0] OFS_ACC = 6'h04;
   localparam logic [5:0] OFS_LOCK = 6'h08;
   localparam logic [5:0] OFS_BSEL = 6'h0c;
   localparam logic [5:0] OFS_PADDR = 6'h10;
   localparam logic [5:0] OFS_PDATA = 6'h14;
   localparam logic [5:0] OFS_CMD = 6'h18;
   localparam logic [5:0] OFS_ERR = 6'h1c;
   localparam logic [5:0] OFS_IST = 6'h20;
   localparam logic [5:0] OFS_IMSK = 6'h24;
   localparam int CFG_PFC = 0;
   localparam int CFG_PFD = 1;
   localparam int CFG_RWS = 2;
   localparam int CFG_XTR = 7;
   localparam logic [11:0] CFG_RST = 12'h003;
   localparam logic [7:0] ACC_RST = 8'hff;
   localparam logic [11:0] LOCK_RST = 12'hfff;
   localparam int CMD_PGM = 0;
   localparam int CMD_ERS = 1;
   localparam int CMD_SUS = 2;
   localparam int CMD_RES = 3;
   localparam int INT_DONE = 0;
   localparam int INT_ECC1 = 1;
   localparam int INT_ECC2 = 2;
   localparam int INT_ACC = 3;
   localparam int NBUF = 4;
   localparam logic [6:0][19:0] CODE_BLK_END = {20'h77fff, 20'h57fff,
      20'h37fff, 20'h17fff, 20'h0ffff, 20'h0bfff, 20'h07fff};

   typedef enum logic [1:0] {S_IDLE, S_ARR, S_CAP, S_ERR} st_t;
   typedef struct packed {logic rd; logic [15:0] line;} nv_req_t;
   typedef struct packed {logic [127:0] data; logic [15:0] ecc;} nv_rsp_t;
   typedef struct packed
   {
      logic pgm;
      logic ers;
      logic [11:0] blk;
      logic [19:0] addr;
      logic [31:0] data;
   } nv_pe_t;

   // Result is {double, single, corrected data}
   function automatic logic [65:0] secded(input logic [63:0] d,
                                          input logic [7:0] c);
      logic [6:0] syn;
      logic par;
      logic [63:0] q;
      int k;
      syn = c[6:0];
      par = ^{d, c};
      q = d;
      k = 0;
      for (int p = 1; p < 72; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (d[k])
               syn = syn ^ p[6:0];
            k++;
         end
      end
      k = 0;
      for (int p = 1; p < 72; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (par && syn == p[6:0])
               q[k] = ~q[k];
            k++;
         end
      end
      return {~par & (syn != 7'h0), par, q};
   endfunction

   // Code blocks 0..6 by end address, data blocks 8..11 of 16 KB each
   function automatic logic [3:0] blk_of(input logic [19:0] a);
      logic [3:0] b;
      b = 4'h8 + {2'b00, a[15:14]};
      if (!a[19])
      begin
         b = 4'h6;
         for (int i = 6; i >= 0; i--)
            if (a <= CODE_BLK_END[i])
               b = 4'(i);
      end
      return b;
   endfunction
endpackage

// File: rtl/flash_ctl.sv
// Flash read, prefetch, protection and program/erase sequencer on AHB-Lite
`timescale 1ns/1ps
`default_nettype none

module flash_ctl
   import flash_ctl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic [1:0] hmaster,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [3:0] prot_rd_off,
   input wire logic [3:0] prot_wr_off,
   output flash_ctl_pkg::nv_req_t nv_req,
   input wire flash_ctl_pkg::nv_rsp_t nv_rsp,
   output flash_ctl_pkg::nv_pe_t nv_pe,
   input wire logic nv_pe_done,
   output logic irq
);
   import flash_ctl_pkg::*;

   st_t st_r;
   logic rdy_r, resp_r, irq_r;
   logic [31:0] rdata_r;
   nv_req_t req_r;
   nv_pe_t pe_r;
   nv_rsp_t cap_r;
   logic [11:0] cfg_r, lock_r, bsel_r, eblk_r;
   logic [7:0] acc_r;
   logic [19:0] paddr_r, err_r, a_r;
   logic [31:0] pdata_r;
   logic [3:0] ist_r, imsk_r, ist_set;
   logic ers_act_r, prg_sus_r;
   logic [127:0] buf_d_r [NBUF];
   logic [15:0] buf_t_r [NBUF];
   logic [NBUF-1:0] buf_v_r;
   logic [1:0] rr_r, hit_idx;
   logic [5:0] cnt_r, cnt_nxt;
   logic fill_r, wr_pend_r, hit;
   logic [5:0] wa_r;
   logic [31:0] rmux;
   logic reg_ok;

   // Address phase decode
   wire logic take = hsel & htrans[1] & hready & (st_r == S_IDLE);
   wire logic csr_sel = haddr[23:22] == RGN_CSR;
   wire logic arr_sel = ~haddr[23];
   wire logic rd_ok = acc_r[hmaster] & ~prot_rd_off[hmaster];
   wire logic wr_ok = acc_r[{1'b1, hmaster}] & ~prot_wr_off[hmaster];
   wire logic code_busy = (pe_r.pgm & ~pe_r.addr[19]) |
                          (pe_r.ers & |pe_r.blk[7:0]);
   wire logic data_busy = (pe_r.pgm & pe_r.addr[19]) |
                          (pe_r.ers & |pe_r.blk[11:8]);
   // only the partition under program/erase refuses reads
   wire logic part_busy = haddr[19] ? data_busy : code_busy;
   wire logic arr_rd_ok = arr_sel & ~hwrite & rd_ok & ~part_busy;
   wire logic pf_on = hprot[0] ? cfg_r[CFG_PFD] : cfg_r[CFG_PFC];
   wire logic use_buf = pf_on & ~haddr[19];
   wire logic csr_ok = csr_sel & reg_ok & (~hwrite | wr_ok);
   wire logic bad = ~(csr_ok | arr_rd_ok);
   wire logic hit_go = take & arr_rd_ok & use_buf & hit;
   wire logic miss_go = take & arr_rd_ok & ~(use_buf & hit);
   wire logic [127:0] hit_line = buf_d_r[hit_idx];
   wire logic [31:0] hit_word = hit_line[{haddr[3:2], 5'b0} +: 32];

   // both 64-bit halves of the 128-bit line are checked
   wire logic [65:0] e0 = secded(cap_r.data[63:0], cap_r.ecc[7:0]);
   wire logic [65:0] e1 = secded(cap_r.data[127:64], cap_r.ecc[15:8]);
   wire logic [127:0] line = {e1[63:0], e0[63:0]};
   wire logic [31:0] word = line[{a_r[3:2], 5'b0} +: 32];
   // data partition page is a 64-bit double word, so only its half counts
   wire logic dbl = a_r[19] ? (a_r[3] ? e1[65] : e0[65]) : (e0[65] | e1[65]);
   wire logic sgl = a_r[19] ? (a_r[3] ? e1[64] : e0[64]) : (e0[64] | e1[64]);

   // Register write side effects
   wire logic cmd_w = wr_pend_r & (wa_r == OFS_CMD);
   wire logic cmd_pgm = cmd_w & hwdata[CMD_PGM];
   wire logic cmd_ers = cmd_w & hwdata[CMD_ERS];
   wire logic cmd_sus = cmd_w & hwdata[CMD_SUS];
   wire logic cmd_res = cmd_w & hwdata[CMD_RES];
   wire logic [3:0] pblk = blk_of(paddr_r);
   wire logic [11:0] pblk_oh = 12'h001 << pblk;
   wire logic pe_idle = ~pe_r.pgm & ~prg_sus_r;
   // program allowed beside a suspended erase, not inside it
   wire logic prg_ok = pe_idle & ~pe_r.ers & ~lock_r[pblk] &
                       ~(ers_act_r & eblk_r[pblk]);
   wire logic ers_ok = pe_idle & ~ers_act_r & (bsel_r != 12'h0) &
                       ((bsel_r & lock_r) == 12'h0);
   wire logic pe_refused = (cmd_pgm & ~prg_ok) | (cmd_ers & ~ers_ok);
   wire logic done_ev = nv_pe_done & (pe_r.pgm | pe_r.ers);

   assign hreadyout = rdy_r;
   assign hresp = resp_r;
   assign hrdata = rdata_r;
   assign nv_req = req_r;
   assign nv_pe = pe_r;
   assign irq = irq_r;

   always_comb
   begin
      hit = 1'b0;
      hit_idx = 2'd0;
      for (int i = 0; i < NBUF; i++)
         if (buf_v_r[i] && buf_t_r[i] == haddr[19:4])
         begin
            hit = 1'b1;
            hit_idx = 2'(i);
         end
   end

   always_comb
   begin
      reg_ok = haddr[21:6] == 16'h0;
      rmux = 32'h0;
      unique case (haddr[5:0])
         OFS_CFG: rmux = {20'h0, cfg_r};
         OFS_ACC: rmux = {24'h0, acc_r};
         OFS_LOCK: rmux = {20'h0, lock_r};
         OFS_BSEL: rmux = {20'h0, bsel_r};
         OFS_PADDR: rmux = {12'h0, paddr_r};
         OFS_PDATA: rmux = pdata_r;
         OFS_CMD: rmux = {28'h0, ers_act_r & ~pe_r.ers, prg_sus_r,
                          pe_r.ers, pe_r.pgm};
         OFS_ERR: rmux = {12'h0, err_r};
         OFS_IST: rmux = {28'h0, ist_r};
         OFS_IMSK: rmux = {28'h0, imsk_r};
         default: reg_ok = 1'b0;
      endcase
   end

   // base read waits plus alias-mapping extra cycles
   assign cnt_nxt = {1'b0, cfg_r[CFG_RWS +: 5]} +
                    (haddr[22] ? {1'b0, cfg_r[CFG_XTR +: 5]} : 6'h0);

   // the master keeps its request until hready, so take needs it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= S_IDLE;
         rdy_r <= 1'b1;
         resp_r <= 1'b0;
         rdata_r <= 32'h0;
         req_r <= '0;
         cnt_r <= 6'h0;
         a_r <= 20'h0;
         fill_r <= 1'b0;
         cap_r <= '0;
      end
      else
      begin
         req_r.rd <= 1'b0;
         unique case (st_r)
            S_IDLE:
            begin
               resp_r <= 1'b0;
               if (take && bad)
               begin
                  rdy_r <= 1'b0;
                  resp_r <= 1'b1;
                  st_r <= S_ERR;
               end
               else if (take && csr_sel)
                  rdata_r <= rmux;
               // hit served at the address phase edge
               else if (hit_go)
                  rdata_r <= hit_word;
               // miss launches the 128-bit array read
               else if (miss_go)
               begin
                  rdy_r <= 1'b0;
                  req_r <= '{rd: 1'b1, line: haddr[19:4]};
                  a_r <= haddr[19:0];
                  fill_r <= use_buf;
                  cnt_r <= cnt_nxt;
                  st_r <= S_ARR;
               end
            end
            S_ARR:
               if (cnt_r == 6'h0)
               begin
                  cap_r <= nv_rsp;
                  st_r <= S_CAP;
               end
               else
                  cnt_r <= cnt_r - 6'h1;
            // registered array data goes out one cycle later
            S_CAP:
               if (dbl)
               begin
                  resp_r <= 1'b1;
                  st_r <= S_ERR;
               end
               else
               begin
                  rdata_r <= word;
                  rdy_r <= 1'b1;
                  st_r <= S_IDLE;
               end
            S_ERR:
            begin
               rdy_r <= 1'b1;
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // buffers hold corrected code lines, filled round robin
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         buf_v_r <= '0;
         rr_r <= 2'd0;
      end
      else if (done_ev)
         buf_v_r <= '0;
      else if (st_r == S_CAP && fill_r && !dbl)
      begin
         buf_v_r[rr_r] <= 1'b1;
         rr_r <= rr_r + 2'd1;
      end
   end

   // Data storage needs no reset; valid bits guard it
   always_ff @(posedge hclk)
      if (st_r == S_CAP && fill_r && !dbl)
      begin
         buf_d_r[rr_r] <= line;
         buf_t_r[rr_r] <= a_r[19:4];
      end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wa_r <= 6'h0;
      end
      else
      begin
         wr_pend_r <= take & csr_ok & hwrite;
         wa_r <= haddr[5:0];
      end
   end

   // Status set wins over write-one-to-clear in the same cycle
   assign ist_set = {(take & bad) | pe_refused, st_r == S_CAP & dbl,
                     st_r == S_CAP & ~dbl & sgl, done_ev};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_r <= CFG_RST;
         acc_r <= ACC_RST;
         lock_r <= LOCK_RST;
         bsel_r <= 12'h0;
         paddr_r <= 20'h0;
         pdata_r <= 32'h0;
         imsk_r <= 4'h0;
         ist_r <= 4'h0;
         err_r <= 20'h0;
         irq_r <= 1'b0;
      end
      else
      begin
         if (wr_pend_r && wa_r == OFS_CFG)
            cfg_r <= hwdata[11:0];
         if (wr_pend_r && wa_r == OFS_ACC)
            acc_r <= hwdata[7:0];
         if (wr_pend_r && wa_r == OFS_LOCK)
            lock_r <= hwdata[11:0];
         if (wr_pend_r && wa_r == OFS_BSEL)
            bsel_r <= hwdata[11:0];
         if (wr_pend_r && wa_r == OFS_PADDR)
            paddr_r <= hwdata[19:0];
         if (wr_pend_r && wa_r == OFS_PDATA)
            pdata_r <= hwdata;
         if (wr_pend_r && wa_r == OFS_IMSK)
            imsk_r <= hwdata[3:0];
         if (wr_pend_r && wa_r == OFS_IST)
            ist_r <= (ist_r & ~hwdata[3:0]) | ist_set;
         else
            ist_r <= ist_r | ist_set;
         // failing address kept for error reporting
         if (st_r == S_CAP && dbl)
            err_r <= a_r;
         irq_r <= |(ist_r & imsk_r);
      end
   end

   // program/erase sequencer; suspend drops the run level
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pe_r <= '0;
         eblk_r <= 12'h0;
         ers_act_r <= 1'b0;
         prg_sus_r <= 1'b0;
      end
      else if (done_ev)
      begin
         if (pe_r.pgm)
            pe_r.pgm <= 1'b0;
         else
         begin
            pe_r.ers <= 1'b0;
            ers_act_r <= 1'b0;
         end
      end
      else if (cmd_pgm && prg_ok)
      begin
         pe_r.pgm <= 1'b1;
         pe_r.blk <= pblk_oh;
         pe_r.addr <= paddr_r;
         pe_r.data <= pdata_r;
      end
      // erase only when no selected block is locked
      else if (cmd_ers && ers_ok)
      begin
         pe_r.ers <= 1'b1;
         pe_r.blk <= bsel_r;
         eblk_r <= bsel_r;
         ers_act_r <= 1'b1;
      end
      else if (cmd_sus)
      begin
         if (pe_r.pgm)
         begin
            pe_r.pgm <= 1'b0;
            prg_sus_r <= 1'b1;
         end
         else
            pe_r.ers <= 1'b0;
      end
      else if (cmd_res)
      begin
         if (prg_sus_r)
         begin
            pe_r.pgm <= 1'b1;
            prg_sus_r <= 1'b0;
         end
         else if (ers_act_r && !pe_r.pgm)
         begin
            pe_r.ers <= 1'b1;
            pe_r.blk <= eblk_r;
         end
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_hit_zero_wait: assert property (hit_go |=> hreadyout && !hresp)
      else $error("buffer hit was not answered without wait");
   a_miss_two_wait: assert property (
      miss_go && cnt_nxt == 6'h0 |=> !hreadyout ##1 !hreadyout ##1
      (hreadyout || hresp))
      else $error("array miss did not take two wait states");
   a_miss_fetch: assert property (
      miss_go |=> nv_req.rd && nv_req.line == $past(haddr[19:4]))
      else $error("array miss did not issue a line read");
   a_wait_count: assert property (
      st_r == S_ARR && cnt_r != 6'h0 |=> st_r == S_ARR &&
      cnt_r == $past(cnt_r) - 6'h1)
      else $error("read wait counter did not step down");
   a_ecc_fix_flag: assert property (
      st_r == S_CAP && sgl && !dbl |=> ist_r[INT_ECC1] &&
      hrdata == $past(word))
      else $error("corrected read not flagged or returned");
   a_dbl_error: assert property (
      st_r == S_CAP && dbl |=> hresp && !hreadyout ##1 hresp && hreadyout)
      else $error("double error did not give an error response");
   a_master_refuse: assert property (
      take && arr_sel && !hwrite && !rd_ok |=> hresp && !hreadyout)
      else $error("refused master read was not answered with error");
   a_other_part_read: assert property (
      take && arr_rd_ok && (pe_r.pgm || pe_r.ers) |=> !hresp)
      else $error("read of idle partition refused during program");
   a_lock_erase: assert property (
      $rose(pe_r.ers) && !$past(ers_act_r) |->
      (($past(bsel_r) & $past(lock_r)) == 12'h0))
      else $error("erase started on a locked block");
   a_suspend_stop: assert property (
      cmd_sus && pe_r.pgm && !nv_pe_done |=> !pe_r.pgm && prg_sus_r)
      else $error("program suspend did not stop the program");
endmodule
`default_nettype wire

// File: dv/nv_array_model.sv
// Behavioural flash array: line reads with check bits, program/erase timing
`timescale 1ns/1ps
`default_nettype none
module nv_array_model
   import flash_ctl_pkg::*;
#(
   parameter int PE_CYC = 8
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire flash_ctl_pkg::nv_req_t nv_req,
   output flash_ctl_pkg::nv_rsp_t nv_rsp,
   input wire flash_ctl_pkg::nv_pe_t nv_pe,
   output logic nv_pe_done,
   input wire logic [5:0] valid_cyc,
   input wire logic [1:0] flip,
   input wire logic hold
);
   logic [15:0] line_r;
   logic [15:0] ln;
   logic [5:0] age_r;
   logic [7:0] pe_cnt_r;
   logic [127:0] clean;
   logic [127:0] bad;
   nv_rsp_t good;

   function automatic logic [31:0] word(input logic [15:0] l,
                                        input logic [1:0] w);
      return {l, ~l[13:0], w};
   endfunction

   function automatic logic [7:0] enc(input logic [63:0] d);
      logic [6:0] s;
      int k;
      s = 7'h0;
      k = 0;
      for (int p = 1; p < 72; p++)
      begin
         if ((p & (p - 1)) != 0)
         begin
            if (d[k])
               s = s ^ p[6:0];
            k++;
         end
      end
      return {^{d, s}, s};
   endfunction

   assign ln = nv_req.rd ? nv_req.line : line_r;
   assign clean = {word(ln, 2'h3), word(ln, 2'h2), word(ln, 2'h1),
      word(ln, 2'h0)};
   assign bad = clean ^ (128'(flip[0]) << 5) ^ (128'(flip[1]) << 9);
   assign good = {bad, enc(clean[127:64]), enc(clean[63:0])};
   // Past the hold window the lines no longer carry the old page
   assign nv_rsp = (nv_req.rd || age_r < valid_cyc) ? good : ~good;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line_r <= 16'h0;
         age_r <= 6'h3f;
      end
      else if (nv_req.rd)
      begin
         line_r <= nv_req.line;
         age_r <= 6'h0;
      end
      else if (age_r != 6'h3f)
         age_r <= age_r + 6'h1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pe_cnt_r <= 8'h0;
         nv_pe_done <= 1'b0;
      end
      else if ((nv_pe.pgm | nv_pe.ers) && !hold && !nv_pe_done)
      begin
         nv_pe_done <= (pe_cnt_r == 8'(PE_CYC));
         pe_cnt_r <= (pe_cnt_r == 8'(PE_CYC)) ? 8'h0 : pe_cnt_r + 8'h1;
      end
      else
      begin
         nv_pe_done <= 1'b0;
         pe_cnt_r <= 8'h0;
      end
   end
endmodule
`default_nettype wire

// File: dv/test_flash_ctl.sv
// Self-checking bench for the flash read and program controller
`timescale 1ns/1ps
`default_nettype none
module test_flash_ctl;
   import flash_ctl_pkg::*;
   localparam logic [31:0] RB = 32'h0080_0000;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic hold, rsp, nv_pe_done;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0] htrans, hmaster, flip;
   logic [3:0] hprot, prot_rd_off, prot_wr_off;
   logic [5:0] valid_cyc;
   nv_req_t nv_req;
   nv_rsp_t nv_rsp;
   nv_pe_t nv_pe;
   int num_errors, n_checks, nwait, cyc;

   assign hready = hreadyout;

   flash_ctl dut_u(.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hprot(hprot), .hmaster(hmaster), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .prot_rd_off(prot_rd_off), .prot_wr_off(prot_wr_off),
      .nv_req(nv_req), .nv_rsp(nv_rsp), .nv_pe(nv_pe),
      .nv_pe_done(nv_pe_done), .irq(irq));

   nv_array_model arr_u(.hclk(hclk), .hresetn(hresetn), .nv_req(nv_req),
      .nv_rsp(nv_rsp), .nv_pe(nv_pe), .nv_pe_done(nv_pe_done),
      .valid_cyc(valid_cyc), .flip(flip), .hold(hold));

   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge hclk);
         cyc++;
         if (cyc == 20000)
         begin
            num_errors++;
            tally_and_finish();
         end
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      nwait = 0;
      @(posedge hclk);
      while (!hreadyout)
      begin
         nwait++;
         @(posedge hclk);
      end
      rdat = hrdata;
      rsp = hresp;
   endtask

   task automatic wr(input logic [5:0] o, input logic [31:0] d);
      xfer(1'b1, RB | 32'(o), d);
   endtask

   // Idle gap first so command status has settled
   task automatic rr(input logic [5:0] o, input logic [31:0] e);
      repeat (2) @(posedge hclk);
      xfer(1'b0, RB | 32'(o), 32'h0);
      chk(rdat, e);
   endtask

   task automatic rd(input logic [31:0] a, input int w);
      xfer(1'b0, a, 32'h0);
      chk(rdat, {a[19:4], ~a[17:4], a[3:2]});
      chk(32'(nwait), 32'(w));
      chk({31'h0, rsp}, 32'h0);
   endtask

   task automatic bad(input logic w, input logic [31:0] a);
      xfer(w, a, 32'h0);
      chk({31'h0, rsp}, 32'h1);
   endtask

   task automatic pe_wait();
      repeat (200)
         if (nv_pe.pgm | nv_pe.ers)
            @(posedge hclk);
   endtask

   task automatic t_reset();
      rr(OFS_CFG, 32'h003);
      rr(OFS_ACC, 32'h0ff);
      rr(OFS_LOCK, 32'hfff);
      bad(1'b0, 32'h00c0_0000);
      chk(32'(nwait), 32'h1);
      rr(OFS_IST, 32'h8);
      wr(OFS_IST, 32'hf);
   endtask

   task automatic t_read();
      rd(32'h124, 2);
      rd(32'h128, 0);
      rd(32'h80010, 2);
      rd(32'h80010, 2);
      wr(OFS_CFG, 32'h002);
      hprot <= 4'h0;
      rd(32'h200, 2);
      rd(32'h204, 2);
      hprot <= 4'h1;
      rd(32'h300, 2);
      rd(32'h304, 0);
      wr(OFS_CFG, 32'h003);
   endtask

   task automatic t_ecc();
      flip <= 2'h1;
      rd(32'h400, 2);
      rr(OFS_IST, 32'h2);
      flip <= 2'h3;
      bad(1'b0, 32'h504);
      flip <= 2'h0;
      rr(OFS_ERR, 32'h504);
      rr(OFS_IST, 32'h6);
      wr(OFS_IST, 32'hf);
   endtask

   task automatic t_prot();
      prot_rd_off <= 4'h2;
      hmaster <= 2'h1;
      bad(1'b0, 32'h600);
      prot_rd_off <= 4'h0;
      rd(32'h600, 2);
      wr(OFS_ACC, 32'h0fb);
      hmaster <= 2'h2;
      bad(1'b0, 32'h700);
      prot_wr_off <= 4'h4;
      bad(1'b1, RB | 32'(OFS_CFG));
      hmaster <= 2'h0;
      prot_wr_off <= 4'h0;
      rr(OFS_CFG, 32'h003);
      rr(OFS_IST, 32'h8);
      wr(OFS_ACC, 32'h0ff);
      wr(OFS_IST, 32'hf);
   endtask

   task automatic t_timing();
      wr(OFS_CFG, 32'h00f);
      valid_cyc <= 6'd3;
      rd(32'h800, 5);
      wr(OFS_CFG, 32'hf83);
      valid_cyc <= 6'd31;
      rd(32'h0040_0900, 33);
      wr(OFS_CFG, 32'h003);
      valid_cyc <= 6'd0;
   endtask

   task automatic t_pe();
      wr(OFS_LOCK, 32'hffe);
      wr(OFS_PADDR, 32'h8000);
      wr(OFS_PDATA, 32'h5a5a0f0f);
      wr(OFS_CMD, 32'h1);
      rr(OFS_IST, 32'h8);
      chk({31'h0, irq}, 32'h0);
      hold <= 1'b1;
      wr(OFS_PADDR, 32'h10);
      wr(OFS_CMD, 32'h1);
      @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, nv_pe.pgm}, 32'h1);
      chk({20'h0, nv_pe.blk}, 32'h001);
      chk({12'h0, nv_pe.addr}, 32'h10);
      chk(nv_pe.data, 32'h5a5a0f0f);
      @(posedge hclk);
      // Program suspend parks the run level, resume restores it
      wr(OFS_CMD, 32'h4);
      rr(OFS_CMD, 32'h4);
      wr(OFS_CMD, 32'h8);
      rr(OFS_CMD, 32'h1);
      bad(1'b0, 32'ha00);
      rd(32'h80020, 2);
      wr(OFS_IMSK, 32'h1);
      hold <= 1'b0;
      pe_wait();
      rr(OFS_IST, 32'h9);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IST, 32'hf);
      @(posedge hclk);
      @(negedge hclk);
      chk({31'h0, irq}, 32'h0);
      @(posedge hclk);
   endtask

   task automatic t_blk();
      logic [19:0] a [10] = '{20'h07fff, 20'h08000, 20'h0c000, 20'h10000,
         20'h18000, 20'h38000, 20'h58000, 20'h80000, 20'h84000, 20'h8c000};
      int b [10] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 11};
      wr(OFS_LOCK, 32'h0);
      for (int i = 0; i < 10; i++)
      begin
         wr(OFS_PADDR, {12'h0, a[i]});
         wr(OFS_CMD, 32'h1);
         @(posedge hclk);
         @(negedge hclk);
         chk({20'h0, nv_pe.blk}, 32'h1 << b[i]);
         @(posedge hclk);
         pe_wait();
      end
   endtask

   task automatic t_susp();
      wr(OFS_LOCK, 32'h002);
      wr(OFS_BSEL, 32'h002);
      wr(OFS_CMD, 32'h2);
      rr(OFS_CMD, 32'h0);
      wr(OFS_LOCK, 32'h0);
      hold <= 1'b1;
      wr(OFS_CMD, 32'h2);
      wr(OFS_CMD, 32'h4);
      rr(OFS_CMD, 32'h8);
      wr(OFS_PADDR, 32'h8004);
      wr(OFS_CMD, 32'h1);
      rr(OFS_CMD, 32'h8);
      wr(OFS_PADDR, 32'h4);
      wr(OFS_CMD, 32'h1);
      rr(OFS_CMD, 32'h9);
      hold <= 1'b0;
      pe_wait();
      wr(OFS_CMD, 32'h8);
      rr(OFS_CMD, 32'h2);
      pe_wait();
      rr(OFS_CMD, 32'h0);
   endtask

   initial
   begin
      num_errors = 0;
      n_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      hprot = 4'h1;
      hmaster = 2'h0;
      prot_rd_off = 4'h0;
      prot_wr_off = 4'h0;
      flip = 2'h0;
      hold = 1'b0;
      valid_cyc = 6'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_read();
      t_ecc();
      t_prot();
      t_timing();
      t_pe();
      t_blk();
      t_susp();
      tally_and_finish();
   end
endmodule
`default_nettype wire
